/* File: core/sac_consts.svh */
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
// Clock period in picoseconds (200 MHz).
`define SAC_CLK_PS 5000
// Conversion time, sleep wake time and nap wake time in their own units.
`define SAC_CONV_US 6
`define SAC_WAKE_MS 3
`define SAC_NAP_NS 620
`define SAC_CONV_CYC ((`SAC_CONV_US * 1000000) / `SAC_CLK_PS)
// Scaled so that no intermediate product overflows a 32-bit int.
`define SAC_WAKE_CYC ((`SAC_WAKE_MS * 1000000) / (`SAC_CLK_PS / 1000))
`define SAC_NAP_CYC ((`SAC_NAP_NS * 1000 + `SAC_CLK_PS - 1) / `SAC_CLK_PS)
`define SAC_RES_W 12
`define SAC_BYTE_W 8
`define SAC_HI_LSB 8
`define SAC_RESULT_RST 12'h000
`endif

/* File: core/sac_ctrl.sv */
// How it works
// R01 - Start on convert falling edge, chip selected.
// R02 - Ignore starts while converting.
// R03 - Busy low throughout each conversion.
// R04 - High byte select picks output byte.
// R05 - Selected and read low: outputs enabled.
// R06 - Host keeps convert pulse narrow.
// R07 - Outputs float until read strobe.
// R08 - Joined strobe starts conversion, shows old result.
// R09 - Result placed before busy rises.
// R10 - Host waits busy high then reads.
// R11 - Each read starts next, returns previous.
// R12 - Only host strobes start conversions.
// R13 - Sleep powers down, ignores starts.
// R14 - Reference ready rises 3ms after sleep release.
// R15 - Nap keeps reference; 620ns wake.
// R16 - Comparator powers after sleep or ready.
// R17 - Self-timed conversion lasts about 6us.
// R18 - Result held until next completion.
`timescale 1ns/10ps
`default_nettype none
`include "sac_consts.svh"
module sac_ctrl
	import sac_pkg::*;
#(
	parameter int WAKE_CYC = `SAC_WAKE_CYC,
	parameter int CONV_CYC = `SAC_CONV_CYC,
	parameter bit BYTE_MODE = 1'b0
) (
	input wire logic mclk, // System clock, 200 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic cs_n, // Chip select, active low.
	input wire logic rd_n, // Read strobe, active low.
	input wire logic convert_start_n, // Conversion start, falling edge.
	input wire logic high_byte_select, // Upper byte select, byte variant.
	input wire logic sleep_n, // Sleep request, active low.
	input wire logic nap_n, // Nap request, active low.
	input wire logic [11:0] sample, // Sampled input as a code.
	output logic busy_n, // Low while converting.
	output logic reference_ready, // Reference settled after sleep.
	output logic comparator_on, // Comparator powered.
	output logic [11:0] data_out, // Data pins output value.
	output logic [11:0] data_oe // Data pins output enable.
);
	sac_sar_if sar_if ();
	sac_state_t state;
	logic conv_q;
	logic [19:0] wake_cnt;
	logic [7:0] nap_cnt;
	logic nap_awake;
	sac_result_t result;
	logic fall;
	logic allow;
	logic [11:0] next_data;
	sac_result_t shown;

	sac_sar #(.CONV_CYC(CONV_CYC)) u_sar (
		.mclk(mclk),
		.rst_n(rst_n),
		.sample(sample),
		.sar(sar_if.sar)
	);

	assign fall = conv_q && !convert_start_n;
	// Only a strobe edge starts a conversion; there is no sample clock.
	assign allow = fall && !cs_n && reference_ready && nap_awake; // R01 R12 R13
	assign sar_if.start = allow && (state == SAC_IDLE); // R02

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			conv_q <= 1'b1;
		end else begin
			conv_q <= convert_start_n;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= SAC_IDLE;
			busy_n <= 1'b1;
		end else begin
			case (state)
				SAC_IDLE: begin
					if (sar_if.start) begin
						state <= SAC_CONV;
						busy_n <= 1'b0; // R03 R08
					end
				end
				SAC_CONV: begin
					if (sar_if.done) begin
						state <= SAC_IDLE;
						busy_n <= 1'b1; // R03
					end
				end
				default: begin
					state <= SAC_IDLE;
					busy_n <= 1'b1;
				end
			endcase
		end
	end

	// Result latches on the same edge busy rises, so data is valid at it.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			result <= `SAC_RESULT_RST;
		end else if (sar_if.done) begin
			result <= sar_if.code; // R09 R18
		end
	end

	// Sleep drops the reference; wake count restarts at each release.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wake_cnt <= 20'h0_0000;
			reference_ready <= 1'b0;
		end else if (!sleep_n) begin
			wake_cnt <= 20'h0_0000;
			reference_ready <= 1'b0; // R13
		end else if (!reference_ready) begin
			if (wake_cnt == 20'(WAKE_CYC - 1)) begin
				reference_ready <= 1'b1; // R14
			end else begin
				wake_cnt <= wake_cnt + 20'h0_0001;
			end
		end
	end

	// Nap keeps the reference alive, so only the short wake applies.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			nap_cnt <= 8'h00;
			nap_awake <= 1'b0;
		end else if (!nap_n || !sleep_n) begin
			nap_cnt <= 8'h00;
			nap_awake <= 1'b0; // R15
		end else if (!nap_awake) begin
			if (nap_cnt == 8'(`SAC_NAP_CYC - 1)) begin
				nap_awake <= 1'b1; // R15
			end else begin
				nap_cnt <= nap_cnt + 8'h01;
			end
		end
	end

	// With ready strapped to nap, nap_n follows ready and so gates power.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			comparator_on <= 1'b0;
		end else begin
			comparator_on <= sleep_n && nap_n; // R16
		end
	end

	// The new code reaches the pins on the edge busy rises, not one later.
	assign shown = sar_if.done ? sar_if.code : result; // R09

	always_comb begin
		next_data = shown;
		if (BYTE_MODE) begin
			next_data = 12'h000;
			if (high_byte_select) begin
				next_data[3:0] = shown[11:8]; // R04
			end else begin
				next_data[7:0] = shown[7:0]; // R04
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `SAC_RES_W; gi++) begin : g_pin
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					data_out[gi] <= 1'b0;
					data_oe[gi] <= 1'b0;
				end else begin
					data_out[gi] <= next_data[gi]; // R05 R11
					data_oe[gi] <= !cs_n && !rd_n &&
						(!BYTE_MODE || gi < `SAC_BYTE_W); // R07
				end
			end
		end
	endgenerate

	property p_start_busy;
		@(posedge mclk) disable iff (!rst_n)
		sar_if.start |=> !busy_n;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("busy not low"); // R03

	property p_no_start_sleep;
		@(posedge mclk) disable iff (!rst_n)
		!sleep_n |-> !sar_if.start;
	endproperty
	a_no_start_sleep: assert property (p_no_start_sleep) else $error("start in sleep"); // R13

	property p_no_restart;
		@(posedge mclk) disable iff (!rst_n)
		(state == SAC_CONV) |-> !sar_if.start;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("restart"); // R02

	sequence s_done;
		sar_if.done;
	endsequence
	property p_done_result;
		@(posedge mclk) disable iff (!rst_n)
		s_done |=> busy_n && result == $past(sar_if.code);
	endproperty
	a_done_result: assert property (p_done_result) else $error("result late"); // R09

	property p_hold;
		@(posedge mclk) disable iff (!rst_n)
		!sar_if.done |=> $stable(result);
	endproperty
	a_hold: assert property (p_hold) else $error("result changed"); // R18

	property p_oe;
		@(posedge mclk) disable iff (!rst_n)
		(cs_n || rd_n) |=> data_oe == 12'h000;
	endproperty
	a_oe: assert property (p_oe) else $error("pins driven"); // R07

	property p_oe_on;
		@(posedge mclk) disable iff (!rst_n)
		(!cs_n && !rd_n) |=> data_oe[0];
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("pins off"); // R05

	property p_start_cond;
		@(posedge mclk) disable iff (!rst_n)
		sar_if.start |-> !cs_n && $fell(convert_start_n);
	endproperty
	a_start_cond: assert property (p_start_cond) else $error("bad start"); // R01

	property p_ready_drop;
		@(posedge mclk) disable iff (!rst_n)
		!sleep_n |=> !reference_ready;
	endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("ready in sleep"); // R14
endmodule
`default_nettype wire

/* File: core/sac_pkg.sv */
package sac_pkg;
	typedef enum logic [1:0] {SAC_IDLE, SAC_CONV} sac_state_t;
	typedef logic [11:0] sac_result_t;
endpackage

/* File: core/sac_sar.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sac_consts.svh"
module sac_sar
	import sac_pkg::*;
#(
	parameter int CONV_CYC = `SAC_CONV_CYC
) (
	input wire logic mclk, // System clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [11:0] sample, // Held analog sample as a code.
	sac_sar_if.sar sar // Start and completion to the controller.
);
	logic [15:0] cnt;
	logic running;

	// Self-timed conversion clock modelled as a fixed cycle count.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 16'h0000;
			running <= 1'b0;
			sar.done <= 1'b0;
			sar.code <= `SAC_RESULT_RST;
		end else begin
			sar.done <= 1'b0;
			if (sar.start && !running) begin
				running <= 1'b1;
				cnt <= 16'(CONV_CYC - 1); // R17
				sar.code <= sample;
			end else if (running) begin
				if (cnt == 16'h0000) begin
					running <= 1'b0;
					sar.done <= 1'b1;
				end else begin
					cnt <= cnt - 16'h0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: core/sac_sar_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface sac_sar_if;
	logic start;
	logic done;
	logic [11:0] code;
	modport ctrl (output start, input done, input code);
	modport sar (input start, output done, output code);
endinterface
`default_nettype wire

/* File: test/sac_host.sv */
`timescale 1ns/10ps
`default_nettype none
module sac_host (
	input wire logic mclk, // System clock.
	input wire logic busy_n, // Converter busy, active low.
	output logic cs_n, // Chip select, active low.
	output logic rd_n, // Read strobe, active low.
	output logic convert_start_n, // Start strobe, active low.
	output logic high_byte_select // Upper byte select.
);
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		convert_start_n = 1'b1;
		high_byte_select = 1'b0;
	end
	task automatic byte_sel(input logic h);
		@(posedge mclk);
		high_byte_select <= h;
	endtask
	task automatic bus(input logic c, input logic r);
		@(posedge mclk);
		cs_n <= c;
		rd_n <= r;
	endtask
	// One cycle low, so the start line rises on the edge that starts the conversion.
	task automatic pulse();
		@(posedge mclk);
		convert_start_n <= 1'b0;
		@(posedge mclk);
		convert_start_n <= 1'b1;
	endtask
	task automatic joined_low();
		@(posedge mclk);
		rd_n <= 1'b0;
		convert_start_n <= 1'b0;
	endtask
	// The host sits in a wait state until busy returns, then releases both strobes.
	task automatic joined_release(output logic ok);
		ok = 1'b0;
		for (int i = 0; i < 40 && !ok; i++) begin
			@(posedge mclk);
			#1;
			ok = (busy_n === 1'b1);
		end
		@(posedge mclk);
		rd_n <= 1'b1;
		convert_start_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: test/sampling_adc_control_and_readout_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module sampling_adc_control_and_readout_bench;
	import sac_pkg::*;
	localparam int CONV = 8;
	localparam int WAKE = 20;
	logic mclk, rst_n, sleep_n, nap_n, busy_n, reference_ready, comparator_on;
	logic cs_n, rd_n, convert_start_n, high_byte_select, ok;
	sac_result_t sample, data_out, data_oe;
	localparam int NAP = 124;
	int err_total, cmp_count, low;
	sac_result_t b_data, b_oe;
	sac_host u_host (.mclk(mclk), .busy_n(busy_n), .cs_n(cs_n), .rd_n(rd_n),
		.convert_start_n(convert_start_n),
		.high_byte_select(high_byte_select));
	sac_ctrl #(.WAKE_CYC(WAKE), .CONV_CYC(CONV), .BYTE_MODE(1'b0)) uut (
		.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
		.convert_start_n(convert_start_n),
		.high_byte_select(high_byte_select), .sleep_n(sleep_n),
		.nap_n(nap_n), .sample(sample), .busy_n(busy_n),
		.reference_ready(reference_ready), .comparator_on(comparator_on),
		.data_out(data_out), .data_oe(data_oe));
	sac_ctrl #(.WAKE_CYC(WAKE), .CONV_CYC(CONV), .BYTE_MODE(1'b1)) uut_b (
		.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
		.convert_start_n(convert_start_n),
		.high_byte_select(high_byte_select), .sleep_n(sleep_n),
		.nap_n(nap_n), .sample(sample), .busy_n(),
		.reference_ready(), .comparator_on(),
		.data_out(b_data), .data_oe(b_oe));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic check(input string what, input logic [11:0] seen,
		input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Counts busy-low edges after the strobe, so a clean run gives CONV.
	task automatic run_conv(input sac_result_t v, input bit again);
		@(posedge mclk);
		sample <= v;
		u_host.pulse();
		low = 0;
		fork
			for (int i = 0; i < 40 && (i == 0 || busy_n === 1'b0); i++) begin
				tick(1);
				if (busy_n === 1'b0) low++;
			end
			if (again) begin
				repeat (3) @(posedge mclk);
				u_host.pulse();
			end
		join
	endtask
	task automatic t_wake();
		tick(1);
		check("busy", busy_n, 1'b1);
		check("oe", data_oe, 12'h000);
		tick(WAKE - 2);
		check("ready early", reference_ready, 1'b0);
		tick(1);
		check("ready", reference_ready, 1'b1);
		check("cmp on", comparator_on, 1'b1);
		tick(NAP);
	endtask
	task automatic t_direct();
		u_host.bus(1'b0, 1'b0);
		run_conv(12'h05a3, 1'b1);
		check("busy cycles", 12'(low), 12'(CONV));
		check("data at busy", data_out, 12'h05a3);
		check("oe", data_oe, 12'h0fff);
		check("low byte", b_data, 12'h00a3);
		check("byte oe", b_oe, 12'h00ff);
		u_host.byte_sel(1'b1);
		tick(1);
		check("high byte", b_data, 12'h0005);
		u_host.byte_sel(1'b0);
		tick(3);
		check("held", data_out, 12'h05a3);
	endtask
	task automatic t_shared();
		u_host.bus(1'b0, 1'b1);
		run_conv(12'h03c6, 1'b0);
		check("busy cycles", 12'(low), 12'(CONV));
		check("float", data_oe, 12'h0000);
		u_host.bus(1'b0, 1'b0);
		tick(1);
		check("read oe", data_oe, 12'h0fff);
		check("read data", data_out, 12'h03c6);
		u_host.bus(1'b1, 1'b1);
		run_conv(12'h0111, 1'b0);
		check("deselected", 12'(low), 12'h0000);
		check("kept", data_out, 12'h03c6);
	endtask
	task automatic t_slow();
		u_host.bus(1'b0, 1'b1);
		@(posedge mclk);
		sample <= 12'h07e1;
		u_host.joined_low();
		tick(2);
		check("wait", busy_n, 1'b0);
		check("old data", data_out, 12'h03c6);
		check("old oe", data_oe, 12'h0fff);
		u_host.joined_release(ok);
		tick(1);
		check("released", ok, 1'b1);
		check("new data", data_out, 12'h07e1);
		@(posedge mclk);
		sample <= 12'h02b4;
		u_host.joined_low();
		tick(2);
		check("rom old", data_out, 12'h07e1);
		u_host.joined_release(ok);
		tick(1);
		check("rom done", ok, 1'b1);
		check("rom new", data_out, 12'h02b4);
	endtask
	task automatic t_power();
		u_host.bus(1'b0, 1'b0);
		@(posedge mclk);
		sleep_n <= 1'b0;
		tick(2);
		check("sleep ready", reference_ready, 1'b0);
		check("sleep cmp", comparator_on, 1'b0);
		run_conv(12'h00f0, 1'b0);
		check("sleep start", 12'(low), 12'h0000);
		@(posedge mclk);
		sleep_n <= 1'b1;
		tick(WAKE + 1);
		check("rewake", reference_ready, 1'b1);
		tick(NAP);
		@(posedge mclk);
		nap_n <= 1'b0;
		tick(2);
		check("nap cmp", comparator_on, 1'b0);
		check("nap ref", reference_ready, 1'b1);
		run_conv(12'h00f0, 1'b0);
		check("nap start", 12'(low), 12'h0000);
		@(posedge mclk);
		nap_n <= 1'b1;
		tick(NAP + 1);
		run_conv(12'h00f0, 1'b0);
		check("nap wake", 12'(low), 12'(CONV));
		check("nap data", data_out, 12'h00f0);
	endtask
	task automatic t_reset();
		@(posedge mclk);
		rst_n <= 1'b0;
		tick(1);
		check("rst busy", busy_n, 1'b1);
		check("rst data", data_out, 12'h0000);
		check("rst oe", data_oe, 12'h0000);
		check("rst ready", reference_ready, 1'b0);
		@(posedge mclk);
		rst_n <= 1'b1;
		tick(2);
		check("rst oe on", data_oe, 12'h0fff);
		check("rst ready low", reference_ready, 1'b0);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		sleep_n = 1'b1;
		nap_n = 1'b1;
		sample = 12'h0000;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		t_wake();
		t_direct();
		t_shared();
		t_slow();
		t_power();
		t_reset();
		test_done();
	end
endmodule
`default_nettype wire
